// [rtl/pcg_regs.svh]
// register indices, field positions, masks and reset values of the peripheral clock gating block
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH
// ----------------------------------------------------------------
// register indices: byte address is four times the index
// ----------------------------------------------------------------
`define PCG_IDX_GATE0 32'h40020420
`define PCG_IDX_SUPPLY 32'h40020423
`define PCG_IDX_GATE1 32'h4002081A
`define PCG_IDX_GATE2 32'h4002081B
`define PCG_IDX_GATE3 32'h4002081C
`define PCG_AXI_AW 34
// ----------------------------------------------------------------
// writable bit masks and reset values
// ----------------------------------------------------------------
`define PCG_MASK_GATE0 8'hBF
`define PCG_MASK_GATE1 8'hFF
`define PCG_MASK_GATE2 8'hFF
`define PCG_MASK_GATE3 8'h01
`define PCG_MASK_SUPPLY 8'h90
`define PCG_RST_BYTE 8'h00
`define PCG_RST_VEC 32'h00000000
`define PCG_BIT_RTC 7
`define PCG_BIT_LPSTOP 7
`define PCG_BIT_SRCSEL 4
// ----------------------------------------------------------------
// positions in the flat 32-bit gate vector {gate3, gate2, gate1, gate0}
// ----------------------------------------------------------------
`define PCG_VEC_RTC 7
`define PCG_VEC_ADC 5
`define PCG_VEC_TMA 8
`define PCG_VEC_DMA 11
`define PCG_VEC_TMM 12
`define PCG_VEC_CSD 20
`define PCG_NGATE 32
// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_DECERR 2'h3
`endif

// [rtl/pcg_pkg.sv]
// types shared by the peripheral clock gating modules
package pcg_pkg;
    typedef enum logic [0:0] {PCG_WR_IDLE = 1'b0, PCG_WR_RESP = 1'b1} pcg_wr_state_t;
    typedef enum logic [0:0] {PCG_RD_IDLE = 1'b0, PCG_RD_RESP = 1'b1} pcg_rd_state_t;
    typedef enum logic [2:0] {
        PCG_SEL_NONE = 3'h0,
        PCG_SEL_GATE0 = 3'h1,
        PCG_SEL_GATE1 = 3'h2,
        PCG_SEL_GATE2 = 3'h3,
        PCG_SEL_GATE3 = 3'h4,
        PCG_SEL_SUPPLY = 3'h5
    } pcg_sel_t;
endpackage : pcg_pkg

// [rtl/pcg_gate_if.sv]
// gate vector and low-power permission from the register file to the gate bank
`timescale 1ns/1ps
`default_nettype none
interface pcg_gate_if;
    logic [31:0] gate;
    logic subsys_ok;
    modport src (output gate, output subsys_ok);
    modport dst (input gate, input subsys_ok);
endinterface : pcg_gate_if
`default_nettype wire

// [rtl/pcg_clk_gate.sv]
// latch based glitch-free clock gate cell
`timescale 1ns/1ps
`default_nettype none
module pcg_clk_gate (
    input wire logic clk,   // free running clock
    input wire logic en,    // gate enable, changes after rising edges
    output logic gclk       // gated clock
);
    logic en_lat;
    // latch is open only while clk is low, so en cannot cut a high phase short
    always_latch begin
        if (!clk) begin
            en_lat = en;
        end
    end
    assign gclk = clk & en_lat;
endmodule : pcg_clk_gate
`default_nettype wire

// [rtl/pcg_bank.sv]
// per-peripheral gated clocks, reset holds, write permits and subsystem clock permits
`timescale 1ns/1ps
`default_nettype none
`include "pcg_regs.svh"
module pcg_bank #(
    parameter int NGATE = `PCG_NGATE
) (
    input wire logic aclk,               // system clock
    input wire logic aresetn,            // synchronous reset, active low
    input wire logic ce,                 // clock enable
    pcg_gate_if.dst gif,                 // gates from register file
    output logic [NGATE-1:0] gclk,       // gated clocks
    output logic [NGATE-1:0] rst_n_q,    // peripheral reset, active low
    output logic [NGATE-1:0] wr_allow_q, // register write permit
    output logic [NGATE-1:0] subsys_en_q // subsystem clock permit
);
    genvar i;
    generate
        for (i = 0; i < NGATE; i++) begin : g_gate
            // clock only runs while the gate bit is set
            pcg_clk_gate u_cg (
                .clk(aclk),
                .en(gif.gate[i]),
                .gclk(gclk[i])
            );
            // clock-stop detection has no reset hold and no write lock
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    rst_n_q[i] <= (i == `PCG_VEC_CSD) ? 1'b1 : 1'b0;
                    wr_allow_q[i] <= (i == `PCG_VEC_CSD) ? 1'b1 : 1'b0;
                    subsys_en_q[i] <= 1'b0;
                end else if (ce) begin
                    rst_n_q[i] <= gif.gate[i] | (i == `PCG_VEC_CSD);
                    wr_allow_q[i] <= gif.gate[i] | (i == `PCG_VEC_CSD);
                    subsys_en_q[i] <= gif.gate[i] & (gif.subsys_ok | (i == `PCG_VEC_RTC));
                end
            end
        end
    endgenerate
endmodule : pcg_bank
`default_nettype wire

// [rtl/pcg_top.sv]
// peripheral clock gating block: register file on AXI4-Lite and the gate bank
// How it works
// - gate zero stops clock, blocks writes, resets
// - gate one supplies clock, permits reads, writes
// - first gate register bit map, bit6 unused
// - second gate register bit map
// - dma runs only while its gate set
// - third gate register bit map
// - clock-stop detect gate only switches clock
// - fourth register: bit0 only, rest zero
// - small variant: fourth register inaccessible
// - low-power stop cuts all but rtc, interval
// - stop bit zero keeps subsystem clock flowing
// - source zero: subsystem clock, no lowspeed timer
// - source one: lowspeed clock, timer chooses either
// - supply register resets to zero
// - supply register takes byte-wide writes
// - rtc gate covers rtc and interval timer
// - rtc gate cleared by power-on only
// - gate registers reset to zero
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_regs.svh"
module pcg_top #(
    parameter int ADDR_W = `PCG_AXI_AW,
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic aclk,                    // system clock, 20 MHz
    input wire logic aresetn,                 // synchronous chip reset, active low
    input wire logic por_n,                   // synchronous power-on reset, active low
    input wire logic ce,                      // clock enable, freezes state when low
    input wire logic [ADDR_W-1:0] s_awaddr,   // write address
    input wire logic s_awvalid,               // write address valid
    output logic s_awready,                   // write address ready
    input wire logic [31:0] s_wdata,          // write data
    input wire logic [3:0] s_wstrb,           // write strobes
    input wire logic s_wvalid,                // write data valid
    output logic s_wready,                    // write data ready
    output logic [1:0] s_bresp,               // write response
    output logic s_bvalid,                    // write response valid
    input wire logic s_bready,                // write response ready
    input wire logic [ADDR_W-1:0] s_araddr,   // read address
    input wire logic s_arvalid,               // read address valid
    output logic s_arready,                   // read address ready
    output logic [31:0] s_rdata,              // read data
    output logic [1:0] s_rresp,               // read response
    output logic s_rvalid,                    // read data valid
    input wire logic s_rready,                // read data ready
    input wire logic deep_sleep,              // chip in deep sleep
    input wire logic cpu_subsys_sleep,        // sleep with cpu on subsystem clock
    input wire logic timer_a_lowspeed_req,    // timer A asks for lowspeed count source
    output logic [31:0] periph_clk,           // gated peripheral clocks
    output logic [31:0] periph_rst_n,         // peripheral resets, active low
    output logic [31:0] periph_wr_allow,      // peripheral register write permits
    output logic [31:0] periph_subsys_en,     // subsystem clock permits
    output logic dma_run,                     // dma engine may run
    output logic rtc_lowspeed_src,            // rtc and interval timer on lowspeed clock
    output logic timer_a_lowspeed             // timer A counts lowspeed clock
);
    import pcg_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] gate0_q;
    logic rtc_gate_q;
    logic [7:0] gate1_q;
    logic [7:0] gate2_q;
    logic [7:0] gate3_q;
    logic [7:0] supply_q;
    pcg_wr_state_t wr_state_q;
    pcg_rd_state_t rd_state_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic wlane0_q;
    logic rtc_lowspeed_q;
    logic timer_a_lowspeed_q;
    logic dma_run_q;
    logic [31:0] gate_vec;
    logic commit;
    pcg_sel_t wsel;
    pcg_sel_t rsel;

    pcg_gate_if gif ();

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // the small variant has no fourth register, so it decodes as unmapped
    function automatic pcg_sel_t decode(input logic [ADDR_W-1:0] a);
        pcg_sel_t s;
        s = PCG_SEL_NONE;
        if (a == {`PCG_IDX_GATE0, 2'b00}) begin
            s = PCG_SEL_GATE0;
        end else if (a == {`PCG_IDX_SUPPLY, 2'b00}) begin
            s = PCG_SEL_SUPPLY;
        end else if (a == {`PCG_IDX_GATE1, 2'b00}) begin
            s = PCG_SEL_GATE1;
        end else if (a == {`PCG_IDX_GATE2, 2'b00}) begin
            s = PCG_SEL_GATE2;
        end else if (a == {`PCG_IDX_GATE3, 2'b00} && LARGE_VARIANT) begin
            s = PCG_SEL_GATE3;
        end
        return s;
    endfunction : decode

    assign wsel = decode(awaddr_q);
    assign rsel = decode(s_araddr);
    assign commit = aw_hold_q && w_hold_q && (wr_state_q == PCG_WR_IDLE);

    // ----------------------------------------------------------------
    // write channel: address and data taken in either order
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= PCG_WR_IDLE;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            s_bvalid <= 1'b0;
            s_bresp <= `PCG_RESP_OKAY;
            awaddr_q <= '0;
            wbyte_q <= `PCG_RST_BYTE;
            wlane0_q <= 1'b0;
        end else if (ce) begin
            if (s_awvalid && s_awready) begin
                aw_hold_q <= 1'b1;
                s_awready <= 1'b0;
                awaddr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_hold_q <= 1'b1;
                s_wready <= 1'b0;
                wbyte_q <= s_wdata[7:0];
                wlane0_q <= s_wstrb[0];
            end
            case (wr_state_q)
                PCG_WR_IDLE: begin
                    if (commit) begin
                        wr_state_q <= PCG_WR_RESP;
                        s_bvalid <= 1'b1;
                        s_bresp <= (wsel == PCG_SEL_NONE) ? `PCG_RESP_DECERR : `PCG_RESP_OKAY;
                    end
                end
                PCG_WR_RESP: begin
                    if (s_bready) begin
                        wr_state_q <= PCG_WR_IDLE;
                        s_bvalid <= 1'b0;
                        aw_hold_q <= 1'b0;
                        w_hold_q <= 1'b0;
                        s_awready <= 1'b1;
                        s_wready <= 1'b1;
                    end
                end
                default: begin
                    wr_state_q <= PCG_WR_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    // only the low byte lane carries data; a write without it changes nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate0_q <= `PCG_RST_BYTE;
            gate1_q <= `PCG_RST_BYTE;
            gate2_q <= `PCG_RST_BYTE;
            gate3_q <= `PCG_RST_BYTE;
            supply_q <= `PCG_RST_BYTE;
        end else if (ce && commit && wlane0_q) begin
            if (wsel == PCG_SEL_GATE0) begin
                gate0_q <= wbyte_q & `PCG_MASK_GATE0;
            end else if (wsel == PCG_SEL_GATE1) begin
                gate1_q <= wbyte_q & `PCG_MASK_GATE1;
            end else if (wsel == PCG_SEL_GATE2) begin
                gate2_q <= wbyte_q & `PCG_MASK_GATE2;
            end else if (wsel == PCG_SEL_GATE3) begin
                gate3_q <= wbyte_q & `PCG_MASK_GATE3;
            end else if (wsel == PCG_SEL_SUPPLY) begin
                supply_q <= wbyte_q & `PCG_MASK_SUPPLY;
            end
        end
    end

    // rtc gate survives every reset except power-on; no bus write lands during chip reset
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            rtc_gate_q <= 1'b0;
        end else if (aresetn && ce && commit && wlane0_q && wsel == PCG_SEL_GATE0) begin
            rtc_gate_q <= wbyte_q[`PCG_BIT_RTC];
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= PCG_RD_IDLE;
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= `PCG_RESP_OKAY;
        end else if (ce) begin
            case (rd_state_q)
                PCG_RD_IDLE: begin
                    if (s_arvalid) begin
                        rd_state_q <= PCG_RD_RESP;
                        s_arready <= 1'b0;
                        s_rvalid <= 1'b1;
                        s_rresp <= (rsel == PCG_SEL_NONE) ? `PCG_RESP_DECERR : `PCG_RESP_OKAY;
                        s_rdata <= '0;
                        if (rsel == PCG_SEL_GATE0) begin
                            s_rdata[7:0] <= {rtc_gate_q, gate0_q[6:0]};
                        end else if (rsel == PCG_SEL_GATE1) begin
                            s_rdata[7:0] <= gate1_q;
                        end else if (rsel == PCG_SEL_GATE2) begin
                            s_rdata[7:0] <= gate2_q;
                        end else if (rsel == PCG_SEL_GATE3) begin
                            s_rdata[7:0] <= gate3_q;
                        end else if (rsel == PCG_SEL_SUPPLY) begin
                            s_rdata[7:0] <= supply_q;
                        end
                    end
                end
                PCG_RD_RESP: begin
                    if (s_rready) begin
                        rd_state_q <= PCG_RD_IDLE;
                        s_rvalid <= 1'b0;
                        s_arready <= 1'b1;
                    end
                end
                default: begin
                    rd_state_q <= PCG_RD_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // clock source selection and dma permit
    // ----------------------------------------------------------------
    // timer A lowspeed choice is refused while rtc runs from the subsystem clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rtc_lowspeed_q <= 1'b0;
            timer_a_lowspeed_q <= 1'b0;
            dma_run_q <= 1'b0;
        end else if (ce) begin
            rtc_lowspeed_q <= supply_q[`PCG_BIT_SRCSEL];
            timer_a_lowspeed_q <= supply_q[`PCG_BIT_SRCSEL] & timer_a_lowspeed_req;
            dma_run_q <= gate_vec[`PCG_VEC_DMA];
        end
    end

    // ----------------------------------------------------------------
    // gate bank
    // ----------------------------------------------------------------
    assign gate_vec = {gate3_q, gate2_q, gate1_q, rtc_gate_q, gate0_q[6:0]};
    assign gif.gate = gate_vec;
    // low-power cut applies only in the two sleep states
    assign gif.subsys_ok = !(supply_q[`PCG_BIT_LPSTOP] && (deep_sleep || cpu_subsys_sleep));

    pcg_bank #(
        .NGATE(`PCG_NGATE)
    ) u_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .gif(gif),
        .gclk(periph_clk),
        .rst_n_q(periph_rst_n),
        .wr_allow_q(periph_wr_allow),
        .subsys_en_q(periph_subsys_en)
    );

    assign dma_run = dma_run_q;
    assign rtc_lowspeed_src = rtc_lowspeed_q;
    assign timer_a_lowspeed = timer_a_lowspeed_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    sequence s_wr_taken;
        commit;
    endsequence
    sequence s_wr_answer;
        s_bvalid && (s_bresp == $past(wsel == PCG_SEL_NONE ? `PCG_RESP_DECERR : `PCG_RESP_OKAY));
    endsequence
    sequence s_lp_cut;
        supply_q[`PCG_BIT_LPSTOP] && deep_sleep && gate_vec[`PCG_VEC_TMM] && gate_vec[`PCG_VEC_RTC];
    endsequence

    a_gate_off_hold: assert property (!gate_vec[`PCG_VEC_ADC] |=> !periph_rst_n[`PCG_VEC_ADC] && !periph_wr_allow[`PCG_VEC_ADC])
        else $error("gated-off peripheral not held");
    a_gate_on_allow: assert property (gate_vec[`PCG_VEC_TMM] |=> periph_rst_n[`PCG_VEC_TMM] && periph_wr_allow[`PCG_VEC_TMM])
        else $error("enabled peripheral not released");
    a_dma_run_follow: assert property (##1 dma_run == $past(gate_vec[`PCG_VEC_DMA]))
        else $error("dma permit does not follow gate");
    a_csd_no_reset: assert property (periph_rst_n[`PCG_VEC_CSD] && periph_wr_allow[`PCG_VEC_CSD])
        else $error("clock-stop detect got reset or lock");
    a_lp_cut_hold: assert property (s_lp_cut |=> !periph_subsys_en[`PCG_VEC_TMM] && periph_subsys_en[`PCG_VEC_RTC])
        else $error("low-power cut wrong");
    a_lp_keep_on: assert property (!supply_q[`PCG_BIT_LPSTOP] && gate_vec[`PCG_VEC_TMA] |=> periph_subsys_en[`PCG_VEC_TMA])
        else $error("subsystem clock cut without stop bit");
    a_timer_a_src: assert property (!supply_q[`PCG_BIT_SRCSEL] |=> !timer_a_lowspeed && !rtc_lowspeed_src)
        else $error("lowspeed source allowed while refused");
    a_reserved_zero: assert property (gate0_q[6] == 1'b0 && gate3_q[7:1] == 7'h00 && supply_q[3:0] == 4'h0)
        else $error("reserved bit set");
    a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write response wrong");
    // rtc gate checks name their own disable so that the chip reset stays visible
    a_rtc_keep_chip: assert property (@(posedge aclk) disable iff (!por_n) !aresetn |=> rtc_gate_q == $past(rtc_gate_q))
        else $error("chip reset disturbed rtc gate");
    a_rtc_por_clear: assert property (@(posedge aclk) disable iff (1'b0) !por_n |=> !rtc_gate_q)
        else $error("power-on reset left rtc gate set");
    a_rd_unmapped: assert property (s_arvalid && s_arready && rsel == PCG_SEL_NONE |=>
        s_rresp == `PCG_RESP_DECERR && s_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    a_rd_upper_zero: assert property (s_rvalid |-> s_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_gate_off_subsys: assert property (!gate_vec[`PCG_VEC_ADC] |=> !periph_subsys_en[`PCG_VEC_ADC])
        else $error("subsystem clock given to gated-off peripheral");
    a_src_sel_on: assert property (supply_q[`PCG_BIT_SRCSEL] |=> rtc_lowspeed_src &&
        timer_a_lowspeed == $past(timer_a_lowspeed_req))
        else $error("lowspeed source choice not honoured");
endmodule : pcg_top
`default_nettype wire

// [verif/pcg_periph_model.sv]
// peripheral stand-in that counts the edges of its gated clock
`timescale 1ns/1ps
`default_nettype none
module pcg_periph_model (
    input wire logic pclk,     // gated clock from the block
    input wire logic prst_n,   // peripheral reset, active low
    output logic [7:0] ticks_q // gated clock edges since reset
);
    // asynchronous clear: a held reset must win while the clock is withheld
    always_ff @(posedge pclk or negedge prst_n) begin
        if (!prst_n) begin
            ticks_q <= 8'h00;
        end else begin
            ticks_q <= ticks_q + 8'h01;
        end
    end
endmodule : pcg_periph_model
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the peripheral clock gating block
`timescale 1ns/1ps
`default_nettype none
`include "pcg_regs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic aclk, aresetn, por_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, deep_sleep, cpu_subsys_sleep, ta_req;
    logic [33:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, periph_clk, periph_rst_n, wr_allow, subsys_en, exp_v;
    logic [1:0] s_bresp, s_rresp, resp, bresp_s, rresp_s;
    logic dma_run, rtc_lowspeed_src, timer_a_lowspeed;
    logic [7:0] tick_tma, tick_tmm, rdat, t;
    logic [33:0] reg_addr [5];
    logic [7:0] reg_mask [5];
    int reg_pos [5];
    int error_cnt = 0;
    int total_checks = 0;
    pcg_top dut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .ce(1'b1),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .deep_sleep(deep_sleep), .cpu_subsys_sleep(cpu_subsys_sleep),
        .timer_a_lowspeed_req(ta_req), .periph_clk(periph_clk), .periph_rst_n(periph_rst_n),
        .periph_wr_allow(wr_allow), .periph_subsys_en(subsys_en), .dma_run(dma_run),
        .rtc_lowspeed_src(rtc_lowspeed_src), .timer_a_lowspeed(timer_a_lowspeed));
    pcg_periph_model tma (.pclk(periph_clk[8]), .prst_n(periph_rst_n[8]), .ticks_q(tick_tma));
    pcg_periph_model tmm (.pclk(periph_clk[12]), .prst_n(periph_rst_n[12]), .ticks_q(tick_tmm));
    // small variant shares the bus; its software never sets the absent units' gate bits
    pcg_top #(.LARGE_VARIANT(1'b0)) dut_small (.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .ce(1'b1),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(), .s_wdata(s_wdata & 32'h0000001F),
        .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(), .s_bresp(bresp_s), .s_bvalid(), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(), .s_rdata(), .s_rresp(rresp_s), .s_rvalid(),
        .s_rready(s_rready), .deep_sleep(deep_sleep), .cpu_subsys_sleep(cpu_subsys_sleep),
        .timer_a_lowspeed_req(ta_req), .periph_clk(), .periph_rst_n(), .periph_wr_allow(),
        .periph_subsys_en(), .dma_run(), .rtc_lowspeed_src(), .timer_a_lowspeed());
    // ----------------------------------------------------------------
    // clock, time-zero values and watchdog
    // ----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        {aresetn, por_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 7'h00;
        {deep_sleep, cpu_subsys_sleep, ta_req, s_awaddr, s_araddr, s_wdata} = '0;
    end
    // whole run is a few hundred cycles; this is generous headroom
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        print_verdict();
    end
    // ----------------------------------------------------------------
    // bus tasks: hold each channel until its own ready is sampled
    // ----------------------------------------------------------------
    task automatic axi_wr(input logic [33:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= {24'h000000, d};
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wready === 1'b1) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        r = s_bresp;
        s_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [33:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        d = s_rdata[7:0];
        r = s_rresp;
        s_rready <= 1'b0;
    endtask : axi_rd
    // bank outputs lag the register by an edge; sample mid-cycle to avoid gated-clock races
    task automatic settle();
        repeat (3) @(posedge aclk);
        @(negedge aclk);
    endtask : settle
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reg_addr = '{{`PCG_IDX_GATE0, 2'b00}, {`PCG_IDX_SUPPLY, 2'b00}, {`PCG_IDX_GATE1, 2'b00},
            {`PCG_IDX_GATE2, 2'b00}, {`PCG_IDX_GATE3, 2'b00}};
        reg_mask = '{8'hBF, 8'h90, 8'hFF, 8'hFF, 8'h01};
        reg_pos = '{0, 0, 8, 16, 24};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        // rows: all ones then all zeros into each register, readback and bank vector
        for (int i = 0; i < 5; i++) begin
            for (int k = 0; k < 2; k++) begin
                axi_wr(reg_addr[i], k ? 8'h00 : 8'hFF, resp);
                `CHK(resp, `PCG_RESP_OKAY)
                axi_rd(reg_addr[i], rdat, resp);
                `CHK(rdat, (k ? 8'h00 : 8'hFF) & reg_mask[i])
                settle();
                exp_v = 32'h00100000 | ((i == 1 || k == 1) ? 32'h0 : {24'h0, reg_mask[i]} << reg_pos[i]);
                `CHK(wr_allow, exp_v)
                `CHK(periph_rst_n, exp_v)
            end
        end
        `CHK({bresp_s, rresp_s}, {`PCG_RESP_DECERR, `PCG_RESP_DECERR})
        // timer A and dma enabled before the peripherals are used
        axi_wr(reg_addr[2], 8'h09, resp);
        settle();
        t = tick_tma;
        settle();
        `CHK(tick_tma, t + 8'd3)
        `CHK(tick_tmm, 8'h00)
        `CHK(dma_run, 1'b1)
        axi_wr(reg_addr[2], 8'h00, resp);
        settle();
        `CHK(dma_run, 1'b0)
        `CHK(tick_tma, 8'h00)
        // subsystem clock permits under low-power stop, in both sleep states
        axi_wr(reg_addr[0], 8'hA0, resp);
        axi_wr(reg_addr[2], 8'h10, resp);
        deep_sleep <= 1'b1;
        axi_wr(reg_addr[1], 8'h80, resp);
        settle();
        `CHK(subsys_en[15:0], 16'h0080)
        @(posedge aclk);
        deep_sleep <= 1'b0;
        cpu_subsys_sleep <= 1'b1;
        ta_req <= 1'b1;
        settle();
        `CHK(subsys_en[15:0], 16'h0080)
        axi_wr(reg_addr[1], 8'h00, resp);
        settle();
        `CHK(subsys_en[15:0], 16'h10A0)
        axi_wr(reg_addr[1], 8'h10, resp);
        settle();
        `CHK({rtc_lowspeed_src, timer_a_lowspeed}, 2'b11)
        axi_wr(reg_addr[1], 8'h00, resp);
        settle();
        `CHK({rtc_lowspeed_src, timer_a_lowspeed}, 2'b00)
        // chip reset keeps the rtc gate, power-on reset clears it
        axi_wr(reg_addr[2], 8'hFF, resp);
        axi_wr(reg_addr[1], 8'h90, resp);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(reg_addr[0], rdat, resp);
        `CHK(rdat, 8'h80)
        axi_rd(reg_addr[2], rdat, resp);
        `CHK(rdat, 8'h00)
        axi_rd(reg_addr[1], rdat, resp);
        `CHK(rdat, 8'h00)
        aresetn <= 1'b0;
        por_n <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        axi_rd(reg_addr[0], rdat, resp);
        `CHK(rdat, 8'h00)
        // unmapped place: decode error and zero data
        axi_wr(34'h000000000, 8'hFF, resp);
        `CHK(resp, `PCG_RESP_DECERR)
        axi_rd(34'h000000000, rdat, resp);
        `CHK({resp, rdat}, {`PCG_RESP_DECERR, 8'h00})
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
